// ---- rtl/pio_pkg.sv ----
// constants, encodings and types shared by both ends of the channel
// assumes a single 25 MHz system clock on both ends
package pio_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PIO_CLK_MHZ = 25;
	localparam int PIO_PHASE_NS = 1000;
	localparam int PIO_PHASE_CYC = (PIO_PHASE_NS * PIO_CLK_MHZ + 999) / 1000;
	localparam int PIO_DIV_W = 5;
	localparam logic [PIO_DIV_W-1:0] PIO_DIV_MAX = PIO_DIV_W'(PIO_PHASE_CYC - 1);

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PIO_DATA_W = 16;
	localparam int PIO_ADDR_W = 8;
	localparam int PIO_CMD_W = 8;
	localparam int PIO_LEVELS = 4;
	localparam int PIO_LVL_W = 2;
	localparam int PIO_FIFO_DEPTH = 32;

	// level that the channel service request line is wired to
	localparam logic [PIO_LVL_W-1:0] PIO_IO_LEVEL = 2'h1;

	// ----------------------------------------------------------------
	// command byte fields
	// ----------------------------------------------------------------
	localparam int PIO_CMD_START = 0;
	localparam int PIO_CMD_IRQ_OFF = 1;
	localparam int PIO_CMD_DIR_IN = 2;
	localparam logic [PIO_CMD_W-1:0] PIO_CMD_RESET = 8'h00;

	// ----------------------------------------------------------------
	// status word fields
	// ----------------------------------------------------------------
	localparam int PIO_ST_STARTED = 0;
	localparam int PIO_ST_RX_FULL = 1;
	localparam int PIO_ST_TX_HELD = 2;
	localparam int PIO_ST_ERR = 3;

	// ----------------------------------------------------------------
	// instructions and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PIO_COMMAND_OUTPUT_INSTR = 3'h0,
		PIO_DATA_OUTPUT_INSTR = 3'h1,
		PIO_DATA_INPUT_INSTR = 3'h2,
		PIO_STATUS_INPUT_INSTR = 3'h3,
		PIO_REQUESTER_ADDRESS_INPUT_INSTR = 3'h4
	} pio_op_e;

	typedef enum logic [1:0] {
		PIO_S_IDLE = 2'h0,
		PIO_S_SETUP = 2'h1,
		PIO_S_STROBE = 2'h3,
		PIO_S_HOLD = 2'h2
	} pio_state_e;

endpackage

// ---- rtl/pio_if.sv ----
// signal bundle of the shared programmed i/o channel
// assumes one controller drives din, so the bench does no resolution via din_oe
`timescale 1ns/1ns
interface pio_if;
	logic [pio_pkg::PIO_ADDR_W-1:0] addr;
	logic cmd_out;
	logic dat_out;
	logic dat_in;
	logic stat_in;
	logic addr_in;
	logic strobe;
	logic tick;
	logic [pio_pkg::PIO_DATA_W-1:0] dout;
	logic [pio_pkg::PIO_DATA_W-1:0] din;
	logic din_oe;
	logic ack;
	logic irq;
	logic prio_in;
	logic prio_out;

	modport proc (
		output addr, cmd_out, dat_out, dat_in, stat_in, addr_in,
		output strobe, tick, dout,
		input din, ack, irq
	);

	modport ctl (
		input addr, cmd_out, dat_out, dat_in, stat_in, addr_in,
		input strobe, tick, dout, prio_in,
		output din, din_oe, ack, irq, prio_out
	);
endinterface

// ---- rtl/pio_proc.sv ----
// processor end of the programmed i/o channel with program level register
// assumes channel inputs are synchronous to clk_sys
`timescale 1ns/1ns
module pio_proc (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// channel
	pio_if.proc ch,
	// instruction request
	input wire logic req_valid,
	output logic req_ready,
	input wire pio_pkg::pio_op_e req_op,
	input wire logic [pio_pkg::PIO_ADDR_W-1:0] req_dev,
	input wire logic [pio_pkg::PIO_DATA_W-1:0] req_acc,
	input wire logic [pio_pkg::PIO_DATA_W-1:0] req_pc,
	// instruction result
	output logic done,
	output logic skipped,
	output logic [pio_pkg::PIO_DATA_W-1:0] acc_out,
	output logic [pio_pkg::PIO_DATA_W-1:0] pc_out,
	// program levels
	input wire logic [pio_pkg::PIO_LEVELS-1:0] irq_lines,
	input wire logic level_end,
	input wire logic inhibit,
	output logic [pio_pkg::PIO_LEVELS-1:0] level_reg,
	output logic [pio_pkg::PIO_LVL_W-1:0] level,
	output logic level_active,
	output logic level_switch
);
	import pio_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		pio_state_e st;
		logic [PIO_DIV_W-1:0] div;
		pio_op_e op;
		logic [PIO_ADDR_W-1:0] dev;
		logic [PIO_DATA_W-1:0] dout;
		logic [PIO_DATA_W-1:0] acc;
		logic [PIO_DATA_W-1:0] pc;
		logic ack;
		logic done;
		logic skip;
		logic [PIO_LEVELS-1:0] lreg;
		logic [PIO_LVL_W-1:0] cur;
		logic active;
		logic sw;
	} pio_proc_s;

	pio_proc_s q;
	pio_proc_s d;
	logic tick;
	logic skip_type;
	logic [PIO_LEVELS-1:0] lset;
	logic [PIO_LEVELS-1:0] lclr;
	logic any_set;
	logic [PIO_LVL_W-1:0] hi;

	// highest numbered set bit wins
	function automatic logic [PIO_LVL_W-1:0] pio_highest(
		input logic [PIO_LEVELS-1:0] v
	);
		logic [PIO_LVL_W-1:0] r;
		r = '0;
		for (int i = 0; i < PIO_LEVELS; i++) begin
			if (v[i]) begin
				r = PIO_LVL_W'(i);
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.sw = 1'b0;
		tick = (q.div == PIO_DIV_MAX);
		d.div = tick ? '0 : q.div + 1'b1;
		skip_type = (q.op == PIO_COMMAND_OUTPUT_INSTR) ||
			(q.op == PIO_DATA_OUTPUT_INSTR) ||
			(q.op == PIO_DATA_INPUT_INSTR);

		unique case (q.st)
			PIO_S_IDLE: begin
				if (req_valid) begin
					d.st = PIO_S_SETUP;
					d.div = '0;
					d.op = req_op;
					d.dev = req_dev;
					d.dout = req_acc;
					d.acc = req_acc;
					d.pc = req_pc;
					d.ack = 1'b0;
				end
			end
			PIO_S_SETUP: begin
				if (tick) begin
					d.st = PIO_S_STROBE;
				end
			end
			PIO_S_STROBE: begin
				if (tick) begin
					d.st = PIO_S_HOLD;
					d.ack = ch.ack;
					unique case (q.op)
						PIO_DATA_INPUT_INSTR: d.acc = ch.din;
						PIO_STATUS_INPUT_INSTR: d.acc = ch.din;
						PIO_REQUESTER_ADDRESS_INPUT_INSTR: begin
							d.acc[7:0] = ch.din[7:0];
						end
						default: d.acc = q.acc;
					endcase
				end
			end
			PIO_S_HOLD: begin
				if (tick) begin
					d.st = PIO_S_IDLE;
					d.done = 1'b1;
					// no skip for status or address input
					d.skip = skip_type && q.ack;
					d.pc = (skip_type && q.ack) ? q.pc + 16'h0002 :
						q.pc + 16'h0001;
				end
			end
		endcase

		// level register: set wins over terminate
		lset = irq_lines;
		lset[PIO_IO_LEVEL] = irq_lines[PIO_IO_LEVEL] | ch.irq;
		lclr = '0;
		if (level_end && q.active) begin
			lclr[q.cur] = 1'b1;
		end
		d.lreg = (q.lreg & ~lclr) | lset;

		// level change only between instructions, postponed by inhibit
		any_set = |q.lreg;
		hi = pio_highest(q.lreg);
		if (q.st == PIO_S_IDLE && !inhibit) begin
			if (!any_set) begin
				d.active = 1'b0;
			end else if (!q.active || hi > q.cur || !q.lreg[q.cur]) begin
				d.cur = hi;
				d.active = 1'b1;
				d.sw = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign req_ready = (q.st == PIO_S_IDLE);
	assign done = q.done;
	assign skipped = q.skip;
	assign acc_out = q.acc;
	assign pc_out = q.pc;
	assign level_reg = q.lreg;
	assign level = q.cur;
	assign level_active = q.active;
	assign level_switch = q.sw;

	assign ch.tick = tick;
	assign ch.addr = q.dev;
	assign ch.cmd_out = (q.st != PIO_S_IDLE) &&
		(q.op == PIO_COMMAND_OUTPUT_INSTR);
	assign ch.dat_out = (q.st != PIO_S_IDLE) &&
		(q.op == PIO_DATA_OUTPUT_INSTR);
	assign ch.dat_in = (q.st != PIO_S_IDLE) &&
		(q.op == PIO_DATA_INPUT_INSTR);
	assign ch.stat_in = (q.st != PIO_S_IDLE) &&
		(q.op == PIO_STATUS_INPUT_INSTR);
	assign ch.addr_in = (q.st != PIO_S_IDLE) &&
		(q.op == PIO_REQUESTER_ADDRESS_INPUT_INSTR);
	assign ch.strobe = (q.st == PIO_S_STROBE);
	assign ch.dout = (ch.cmd_out || ch.dat_out) ? q.dout : '0;

endmodule

// ---- rtl/pio_ctl.sv ----
// device controller end of the programmed i/o channel and its fifo
// assumes channel inputs are synchronous to clk_sys
`timescale 1ns/1ns
module pio_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW + 1)'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} pio_fifo_s;

	pio_fifo_s q;
	pio_fifo_s d;
	logic push;
	logic pop;

	always_comb begin
		d = q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign in_ready = (q.cnt != FULL);
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];
endmodule

module pio_ctl #(
	parameter logic [pio_pkg::PIO_ADDR_W-1:0] DEV_ADDR = 8'h01
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// channel
	pio_if.ctl ch,
	// received output data
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [pio_pkg::PIO_DATA_W-1:0] rx_data,
	// data to be read by the processor
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [pio_pkg::PIO_DATA_W-1:0] tx_data,
	// device conditions
	input wire logic err,
	input wire logic term,
	input wire logic byte_mode,
	// command register
	output logic [pio_pkg::PIO_CMD_W-1:0] cmd_word,
	output logic cmd_pulse
);
	import pio_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic strb;
		logic ack;
		logic oe;
		logic [PIO_DATA_W-1:0] din;
		logic [PIO_CMD_W-1:0] cmd;
		logic cmdp;
		logic [PIO_DATA_W-1:0] tx;
		logic txv;
	} pio_ctl_s;

	pio_ctl_s q;
	pio_ctl_s d;
	logic rise;
	logic fall;
	logic match;
	logic started;
	logic dir_in;
	logic want;
	logic pending;
	logic push;
	logic fifo_ready;
	logic [PIO_DATA_W-1:0] push_data;
	logic [PIO_DATA_W-1:0] status;

	assign rise = ch.strobe && !q.strb;
	assign fall = !ch.strobe && q.strb;
	assign match = (ch.addr == DEV_ADDR);
	assign started = q.cmd[PIO_CMD_START];
	assign dir_in = q.cmd[PIO_CMD_DIR_IN];
	assign want = started && (dir_in ? q.txv : fifo_ready);
	assign pending = want && !q.cmd[PIO_CMD_IRQ_OFF];
	assign push = rise && ch.dat_out && match && started && !dir_in &&
		fifo_ready && !term;
	assign push_data = byte_mode ? {8'h00, ch.dout[7:0]} : ch.dout;

	always_comb begin
		status = '0;
		status[PIO_ST_STARTED] = started;
		status[PIO_ST_RX_FULL] = !fifo_ready;
		status[PIO_ST_TX_HELD] = q.txv;
		status[PIO_ST_ERR] = err;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.strb = ch.strobe;
		d.cmdp = 1'b0;
		if (!q.txv && tx_valid) begin
			d.tx = tx_data;
			d.txv = 1'b1;
		end
		if (rise) begin
			if (ch.cmd_out && match && !err) begin
				d.cmd = ch.dout[PIO_CMD_W-1:0];
				d.cmdp = 1'b1;
				d.ack = 1'b1;
			end
			if (push) begin
				d.ack = 1'b1;
			end
			if (ch.dat_in && match) begin
				d.oe = 1'b1;
				d.din = q.tx;
				if (started && dir_in && q.txv && !term) begin
					d.ack = 1'b1;
					d.txv = 1'b0;
				end
			end
			if (ch.stat_in && match) begin
				d.oe = 1'b1;
				d.din = status;
			end
			// address lines are not looked at here
			if (ch.addr_in && pending && !ch.prio_in) begin
				d.oe = 1'b1;
				d.din = {8'h00, DEV_ADDR};
			end
		end
		if (fall) begin
			d.ack = 1'b0;
			d.oe = 1'b0;
			d.din = '0;
		end
	end

	// ----------------------------------------------------------------
	// registers and buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	pio_fifo #(
		.W(PIO_DATA_W),
		.D(PIO_FIFO_DEPTH)
	) i_pio_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ch.ack = q.ack;
	assign ch.din = q.din;
	assign ch.din_oe = q.oe;
	assign ch.irq = pending && !ch.prio_in;
	assign ch.prio_out = ch.prio_in || pending;
	assign tx_ready = !q.txv;
	assign cmd_word = q.cmd;
	assign cmd_pulse = q.cmdp;

endmodule

// ---- tb/pio_monitor.sv ----
// interface-level checks of the programmed i/o channel
// assumes its inputs are taken straight from the joining interface
`timescale 1ns/1ns
module pio_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// channel
	input wire logic [7:0] addr,
	input wire logic cmd_out,
	input wire logic dat_out,
	input wire logic dat_in,
	input wire logic stat_in,
	input wire logic addr_in,
	input wire logic strobe,
	input wire logic tick,
	input wire logic [15:0] dout,
	input wire logic [15:0] din,
	input wire logic din_oe,
	input wire logic ack,
	input wire logic irq,
	input wire logic prio_in,
	input wire logic prio_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ----
	// strobe length counter
	// ----
	logic [5:0] hi_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hi_q <= 6'h00;
		end else begin
			hi_q <= strobe ? hi_q + 6'h01 : 6'h00;
		end
	end
	sequence s_tick_gap;
		##1 !tick ##24 tick;
	endsequence
	// ----
	// checks
	// ----
	strobe_qual_a: assert property (
		strobe |-> $onehot({cmd_out, dat_out, dat_in, stat_in, addr_in}))
		else $error("strobe without a single qualifier");
	strobe_len_a: assert property (
		$fell(strobe) |-> hi_q == 6'h19)
		else $error("strobe length wrong");
	tick_rate_a: assert property (
		tick && strobe |-> s_tick_gap)
		else $error("tick period wrong");
	bus_stable_a: assert property (
		strobe && $past(strobe) |-> $stable(addr) && $stable(dout))
		else $error("address or data moved in strobe");
	dout_idle_a: assert property (
		!(cmd_out || dat_out) |-> dout == 16'h0000)
		else $error("data out driven on input");
	ack_window_a: assert property (
		ack |-> strobe || $past(strobe))
		else $error("ack outside strobe");
	no_skip_ack_a: assert property (
		stat_in || addr_in |-> !ack)
		else $error("ack on status or address input");
	din_idle_a: assert property (
		!din_oe |-> din == 16'h0000)
		else $error("data in not released");
	din_qual_a: assert property (
		din_oe |-> dat_in || stat_in || addr_in)
		else $error("data in driven without input");
	req_addr_a: assert property (
		addr_in && din_oe |-> din[15:8] == 8'h00)
		else $error("requester address upper byte");
	chain_a: assert property (
		(prio_in |-> !irq) and (irq |-> prio_out))
		else $error("precedence chain broken");
endmodule

// ---- tb/programmed_io_channel_tb_top.sv ----
// self-checking bench joining processor and controller ends
// assumes one controller on the channel, so din has one driver
`timescale 1ns/1ns
module programmed_io_channel_tb_top;
	import pio_pkg::*;
	localparam logic [7:0] DEV = 8'h2a;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready, done, skipped, level_active, level_switch;
	pio_op_e req_op = PIO_COMMAND_OUTPUT_INSTR;
	logic [7:0] req_dev = 8'h00;
	logic [7:0] cmd_word;
	logic [15:0] req_acc = 16'h0000, req_pc = 16'h0000, tx_data = 16'h0000;
	logic [15:0] acc_out, pc_out, rx_data, w;
	logic [3:0] irq_lines = 4'h0, level_reg;
	logic [1:0] level;
	logic level_end = 1'b0, inhibit = 1'b0, rx_ready = 1'b0, tx_valid = 1'b0;
	logic err = 1'b1, term = 1'b0, byte_mode = 1'b0, rx_valid, tx_ready;
	logic cmd_pulse;
	int n_cmd = 0, n_sw = 0;
	int n_fail = 0, checks = 0, seed = 32'hcc18f309;
	logic [15:0] q[$];
	pio_if ch ();
	always #20 clk_sys = ~clk_sys;
	// pulse counters, read while the pulses stand
	always @(negedge clk_sys) begin
		if (cmd_pulse === 1'b1) n_cmd++;
		if (level_switch === 1'b1) n_sw++;
	end
	pio_proc i_pio_proc (.clk_sys, .reset_n, .ch(ch.proc), .req_valid,
		.req_ready, .req_op, .req_dev, .req_acc, .req_pc, .done, .skipped,
		.acc_out, .pc_out, .irq_lines, .level_end, .inhibit, .level_reg,
		.level, .level_active, .level_switch);
	pio_ctl #(.DEV_ADDR(DEV)) i_pio_ctl (.clk_sys, .reset_n, .ch(ch.ctl),
		.rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data,
		.err, .term, .byte_mode, .cmd_word, .cmd_pulse);
	pio_monitor i_pio_monitor (.clk_sys, .reset_n, .addr(ch.addr),
		.cmd_out(ch.cmd_out), .dat_out(ch.dat_out), .dat_in(ch.dat_in),
		.stat_in(ch.stat_in), .addr_in(ch.addr_in), .strobe(ch.strobe),
		.tick(ch.tick), .dout(ch.dout), .din(ch.din), .din_oe(ch.din_oe),
		.ack(ch.ack), .irq(ch.irq), .prio_in(ch.prio_in),
		.prio_out(ch.prio_out));
	// ----
	// report and compare
	// ----
	task automatic stop_test();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic hang(input string what);
		n_fail++;
		$display("[ERR] %0t timeout %s", $time, what);
		stop_test();
	endtask
	// one instruction, then its results
	task automatic run(input pio_op_e op, input logic [15:0] acc,
		input logic ack_e, input logic [15:0] acc_e,
		input logic [7:0] dev = DEV);
		int n;
		logic [15:0] pc;
		pc = 16'($random(seed));
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= op;
		req_dev <= dev;
		req_acc <= acc;
		req_pc <= pc;
		n = 0;
		@(negedge clk_sys);
		while (req_ready !== 1'b1) begin
			if (++n > 200) hang("ready");
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			if (++n > 100) hang("done");
		end while (done !== 1'b1);
		chk(pc_out, pc + (ack_e ? 16'h0002 : 16'h0001), "pc");
		chk(16'(skipped), 16'(ack_e), "skip");
		chk(acc_out, acc_e, "acc");
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		ch.prio_in <= 1'b0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		run(PIO_COMMAND_OUTPUT_INSTR, 16'h0001, 1'b0, 16'h0001);
		@(posedge clk_sys);
		err <= 1'b0;
		run(PIO_COMMAND_OUTPUT_INSTR, 16'h0001, 1'b0, 16'h0001, 8'h55);
		w = {8'($random(seed)), 8'h01};
		run(PIO_COMMAND_OUTPUT_INSTR, w, 1'b1, w);
		chk(16'(cmd_word), 16'h0001, "cmd");
		chk(16'(ch.irq), 16'h0001, "irq on");
		run(PIO_STATUS_INPUT_INSTR, 16'hffff, 1'b0, 16'h0001);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys);
			ch.prio_in <= p[0];
			run(PIO_REQUESTER_ADDRESS_INPUT_INSTR, 16'hbe00, 1'b0,
				{8'hbe, p ? 8'h00 : DEV}, 8'h55);
		end
		@(posedge clk_sys);
		ch.prio_in <= 1'b0;
		for (int i = 0; i < 33; i++) begin
			w = 16'($random(seed));
			@(posedge clk_sys);
			byte_mode <= w[0];
			if (i < 32) q.push_back(w[0] ? {8'h00, w[7:0]} : w);
			run(PIO_DATA_OUTPUT_INSTR, w, i < 32, w);
		end
		run(PIO_STATUS_INPUT_INSTR, 16'h0000, 1'b0, 16'h0003);
		chk(16'(ch.irq), 16'h0000, "irq full");
		@(posedge clk_sys);
		rx_ready <= 1'b1;
		for (int n = 0; q.size() > 0; n++) begin
			@(negedge clk_sys);
			if (n > 500) hang("drain");
			if (rx_valid === 1'b1) chk(rx_data, q.pop_front(), "rx");
		end
		run(PIO_COMMAND_OUTPUT_INSTR, 16'h0005, 1'b1, 16'h0005);
		for (int t = 0; t < 2; t++) begin
			w = 16'($random(seed));
			@(posedge clk_sys);
			rx_ready <= 1'b0;
			term <= t[0];
			tx_valid <= 1'b1;
			tx_data <= w;
			@(posedge clk_sys);
			tx_valid <= 1'b0;
			run(PIO_DATA_INPUT_INSTR, 16'h0000, !t[0], w);
		end
		@(posedge clk_sys);
		term <= 1'b0;
		run(PIO_COMMAND_OUTPUT_INSTR, 16'h0007, 1'b1, 16'h0007);
		chk(16'(ch.irq), 16'h0000, "irq off");
		for (int l = 2; l < 5; l++) begin
			@(posedge clk_sys);
			inhibit <= (l == 3);
			irq_lines <= 4'(1 << (l == 4 ? 3 : l));
			@(posedge clk_sys);
			irq_lines <= 4'h0;
			repeat (4) @(negedge clk_sys);
			chk(16'(level), 16'(l == 4 ? 3 : 2), "level");
		end
		@(posedge clk_sys);
		level_end <= 1'b1;
		@(posedge clk_sys);
		level_end <= 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(16'({level_reg, level}), 16'h001a, "level end");
		chk(16'(level_active), 16'h0001, "active");
		chk(16'(n_sw), 16'h0004, "switches");
		chk(16'(n_cmd), 16'h0003, "commands");
		stop_test();
	end
endmodule
